// [cidac_top.sv]
// identification, cache geometry and auxiliary control register bank
`timescale 1ns/100ps
`default_nettype none
`include "cidac_regs.svh"

// Operation
// - cache level field reads zero, writes ignored
// - side select bit picks which geometry shown
// - selection privileged only, one copy per security
// - absent selected cache reads all zeros
// - geometry read-only, banked, follows selection
// - four top geometry attribute bits read one
// - ways two for instruction, four for data
// - line code reads one: eight words
// - revision unprivileged faults; nonsecure reads zero
// - revision readable by enabled unprivileged debugger
// - revision low nibble mirrors pin, read-only
// - aux privileged only, banked, nonsecure alias
// - aux control fields clear on reset; flush disable on cold reset only
// - read-under-write block waits for writes
// - dual issue limit codes full or noarith
// - read-under-read block waits for reads
// - event enable drives event port, shared
// - event lock keeps enable secure only
// - flush disable ignores request, ready high
// - loop disable overrides loop branch prediction
// - fold disable stops all dual issue
module cidac_top #(
  parameter bit          INSTR_CACHE_PRESENT = 1'b1,
  parameter bit          DATA_CACHE_PRESENT  = 1'b1,
  parameter bit          SECURITY_EXT        = 1'b1,
  parameter logic [14:0] INSTR_SETS_CODE     = 15'h007F,
  parameter logic [14:0] DATA_SETS_CODE      = 15'h003F,
  parameter logic [3:0]  IRQ_LINES_CODE      = 4'h0,
  parameter logic [27:0] REVISION_UPPER      = 28'h0000000
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cold_resetn,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_priv,
  input  wire logic        i_secure,
  input  wire logic        i_debug,
  input  wire logic        i_dbg_uid_en_s,
  input  wire logic        i_dbg_uid_en_ns,
  input  wire logic [3:0]  i_revision_number,
  input  wire logic        i_axi_writes_pending,
  input  wire logic        i_axi_reads_pending,
  input  wire logic        i_crit_read_req,
  input  wire logic        i_event_in,
  input  wire logic        i_trace_flush_valid,
  input  wire logic        i_trace_flush_done,
  output logic             o_ack,
  output logic             o_fault,
  output cidac_pkg::cidac_word_t o_rdata,
  output logic             o_crit_read_allow,
  output logic             o_dual_issue_en,
  output logic             o_arith_dual_en,
  output logic             o_loops_en,
  output logic             o_loop_pred_en,
  output logic             o_event_out,
  output logic             o_trace_flush_ready
);

  logic        csel_s_q;
  logic        csel_ns_q;
  logic [31:0] aux_s_q;
  logic [31:0] aux_ns_q;
  logic        ev_en_q;
  logic        ev_lock_q;
  logic        tr_flush_q;
  logic        sel_cur;
  logic        bank_ns;
  logic        is_priv_ok;
  logic [31:0] geom;
  logic [31:0] aux_view;
  logic [31:0] rdata_d;
  logic        fault_d;
  logic        wr_csel;
  logic        wr_aux;

  // alias address always targets the nonsecure copy
  assign bank_ns    = !i_secure || (i_addr == `CIDAC_ADDR_AUX_CTRL_NS);
  assign sel_cur    = i_secure ? csel_s_q : csel_ns_q;
  assign is_priv_ok = i_priv;

  // geometry follows this state's own selection
  always_comb begin
    geom = 32'h00000000;
    if (sel_cur) begin
      if (INSTR_CACHE_PRESENT) begin
        geom = {`CIDAC_GEOM_ATTR, INSTR_SETS_CODE, `CIDAC_WAYS_INSTR,
                `CIDAC_LINE_CODE};
      end
    end else begin
      if (DATA_CACHE_PRESENT) begin
        geom = {`CIDAC_GEOM_ATTR, DATA_SETS_CODE, `CIDAC_WAYS_DATA,
                `CIDAC_LINE_CODE};
      end
    end
  end

  always_comb begin
    aux_view = bank_ns ? aux_ns_q : aux_s_q;
    aux_view[`CIDAC_BIT_TR_FLUSH] = tr_flush_q;
    aux_view[`CIDAC_BIT_EV_EN]    = (bank_ns && ev_lock_q) ? 1'b0 : ev_en_q;
    aux_view[`CIDAC_BIT_EV_LOCK]  = bank_ns ? 1'b0 : ev_lock_q;
  end

  // read decode and fault; writes to read-only words are ignored
  always_comb begin
    rdata_d = 32'h00000000;
    fault_d = 1'b0;
    wr_csel = 1'b0;
    wr_aux  = 1'b0;
    if (i_addr == `CIDAC_ADDR_CACHE_SEL) begin
      if (!is_priv_ok) begin
        fault_d = 1'b1;
      end else begin
        rdata_d = {31'h00000000, sel_cur};
        wr_csel = i_write;
      end
    end else if (i_addr == `CIDAC_ADDR_CACHE_GEOM) begin
      if (!is_priv_ok) begin
        fault_d = 1'b1;
      end else begin
        rdata_d = geom;
      end
    end else if (i_addr == `CIDAC_ADDR_REVISION) begin
      if (i_debug && (i_dbg_uid_en_s || i_dbg_uid_en_ns)) begin
        rdata_d = {REVISION_UPPER, i_revision_number};
      end else if (!is_priv_ok) begin
        fault_d = 1'b1;
      end else if (!(SECURITY_EXT && !i_secure)) begin
        rdata_d = {REVISION_UPPER, i_revision_number};
      end
    end else if (i_addr == `CIDAC_ADDR_AUX_CTRL ||
                 (i_addr == `CIDAC_ADDR_AUX_CTRL_NS && i_secure)) begin
      if (!is_priv_ok) begin
        fault_d = 1'b1;
      end else begin
        rdata_d = aux_view;
        wr_aux  = i_write;
      end
    end else if (i_addr == `CIDAC_ADDR_IRQ_LINES) begin
      rdata_d = {28'h0000000, IRQ_LINES_CODE};
    end else if (i_addr == `CIDAC_ADDR_CP_POWER) begin
      rdata_d = 32'h00000000;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack   <= 1'b0;
      o_fault <= 1'b0;
      o_rdata <= 32'h00000000;
    end else begin
      o_ack   <= i_req;
      o_fault <= i_req && fault_d;
      o_rdata <= (i_req && !i_write && !fault_d) ? rdata_d : 32'h00000000;
    end
  end

  // one selection copy per security state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      csel_s_q  <= `CIDAC_CSEL_RESET;
      csel_ns_q <= `CIDAC_CSEL_RESET;
    end else if (i_req && wr_csel) begin
      if (i_secure) begin
        csel_s_q <= i_wdata[0];
      end else begin
        csel_ns_q <= i_wdata[0];
      end
    end
  end

  // banked aux copies; event and flush bits live apart
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aux_s_q  <= `CIDAC_AUX_RESET;
      aux_ns_q <= `CIDAC_AUX_RESET;
    end else if (i_req && wr_aux) begin
      if (bank_ns) begin
        aux_ns_q <= i_wdata & `CIDAC_AUX_RW_MASK;
      end else begin
        aux_s_q <= i_wdata & `CIDAC_AUX_RW_MASK;
      end
    end
  end

  // shared event bits, cleared by warm reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_en_q   <= 1'b0;
      ev_lock_q <= 1'b0;
    end else if (i_req && wr_aux) begin
      if (!(bank_ns && ev_lock_q)) begin
        ev_en_q <= i_wdata[`CIDAC_BIT_EV_EN];
      end
      if (!bank_ns) begin
        ev_lock_q <= i_wdata[`CIDAC_BIT_EV_LOCK];
      end
    end
  end

  // flush disable survives warm reset, only cold reset clears it
  always_ff @(posedge i_clk or negedge i_cold_resetn) begin
    if (!i_cold_resetn) begin
      tr_flush_q <= 1'b0;
    end else if (i_resetn && i_req && wr_aux) begin
      tr_flush_q <= i_wdata[`CIDAC_BIT_TR_FLUSH];
    end
  end

  // feature controls ignore the running state; only the secure copy steers the core
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_crit_read_allow <= 1'b0;
      o_dual_issue_en   <= 1'b0;
      o_arith_dual_en   <= 1'b0;
      o_loops_en        <= 1'b0;
      o_loop_pred_en    <= 1'b0;
    end else begin
      o_crit_read_allow <= i_crit_read_req &&
        !(aux_s_q[`CIDAC_BIT_RUW] && i_axi_writes_pending) &&
        !(aux_s_q[`CIDAC_BIT_RUR] && i_axi_reads_pending);
      o_dual_issue_en   <= !aux_s_q[`CIDAC_BIT_FOLD];
      o_arith_dual_en   <= !aux_s_q[`CIDAC_BIT_FOLD] &&
        (aux_s_q[`CIDAC_BIT_DI_HI:`CIDAC_BIT_DI_LO] == `CIDAC_DI_FULL);
      o_loops_en        <= !aux_s_q[`CIDAC_BIT_LOOP];
      o_loop_pred_en    <= !aux_s_q[`CIDAC_BIT_LOOP] &&
        !aux_s_q[`CIDAC_BIT_LOOP_BR];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_event_out         <= 1'b0;
      o_trace_flush_ready <= 1'b0;
    end else begin
      o_event_out         <= ev_en_q && i_event_in;
      o_trace_flush_ready <= tr_flush_q ? 1'b1 :
        (i_trace_flush_valid && i_trace_flush_done);
    end
  end

  property p_geom_attr;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && i_addr == `CIDAC_ADDR_CACHE_GEOM && sel_cur &&
       INSTR_CACHE_PRESENT)
      |=> (o_rdata[31:28] == 4'hF && o_rdata[12:3] == 10'h001 && o_rdata[2:0] == 3'h1);
  endproperty
  a_geom_attr: assert property (p_geom_attr) else $error("geometry fields wrong");

  property p_geom_data;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && i_addr == `CIDAC_ADDR_CACHE_GEOM && !sel_cur &&
       DATA_CACHE_PRESENT)
      |=> (o_rdata[12:3] == 10'h003);
  endproperty
  a_geom_data: assert property (p_geom_data) else $error("data ways wrong");

  property p_unpriv_fault;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_priv && !i_debug && i_addr == `CIDAC_ADDR_AUX_CTRL) |=> o_fault;
  endproperty
  a_unpriv_fault: assert property (p_unpriv_fault) else $error("no fault");

  property p_rev_pin;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && i_secure && i_addr == `CIDAC_ADDR_REVISION)
      |=> (o_rdata[3:0] == $past(i_revision_number));
  endproperty
  a_rev_pin: assert property (p_rev_pin) else $error("revision pin mismatch");

  property p_level_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && i_addr == `CIDAC_ADDR_CACHE_SEL) |=> (o_rdata[3:1] == 3'h0);
  endproperty
  a_level_zero: assert property (p_level_zero) else $error("level not zero");

  property p_ruw_block;
    @(posedge i_clk) disable iff (!i_resetn)
      (aux_s_q[`CIDAC_BIT_RUW] && i_axi_writes_pending) |=> !o_crit_read_allow;
  endproperty
  a_ruw_block: assert property (p_ruw_block) else $error("read passed writes");

  property p_fold;
    @(posedge i_clk) disable iff (!i_resetn)
      aux_s_q[`CIDAC_BIT_FOLD] |=> (!o_dual_issue_en && !o_arith_dual_en);
  endproperty
  a_fold: assert property (p_fold) else $error("dual issue not off");

  property p_flush_high;
    @(posedge i_clk) disable iff (!i_resetn)
      tr_flush_q |=> o_trace_flush_ready;
  endproperty
  a_flush_high: assert property (p_flush_high) else $error("flush ready low");

  property p_sel_unpriv;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_priv && i_addr == `CIDAC_ADDR_CACHE_SEL) |=> o_fault;
  endproperty
  a_sel_unpriv: assert property (p_sel_unpriv) else $error("selection no fault");

  property p_geom_absent;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && i_addr == `CIDAC_ADDR_CACHE_GEOM &&
       (sel_cur ? !INSTR_CACHE_PRESENT : !DATA_CACHE_PRESENT))
      |=> (o_rdata == 32'h00000000);
  endproperty
  a_geom_absent: assert property (p_geom_absent) else $error("geometry not zero");

  property p_rev_nonsec;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && !i_secure && !i_debug && SECURITY_EXT &&
       i_addr == `CIDAC_ADDR_REVISION) |=> (o_rdata == 32'h00000000);
  endproperty
  a_rev_nonsec: assert property (p_rev_nonsec) else $error("revision not zero");

  property p_rev_debug;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_debug && (i_dbg_uid_en_s || i_dbg_uid_en_ns) &&
       i_addr == `CIDAC_ADDR_REVISION)
      |=> (!o_fault && o_rdata[3:0] == $past(i_revision_number));
  endproperty
  a_rev_debug: assert property (p_rev_debug) else $error("debug revision wrong");

  // checked while reset is low, so no disable here
  property p_aux_reset;
    @(posedge i_clk)
      !i_resetn |-> (aux_s_q == `CIDAC_AUX_RESET && aux_ns_q == `CIDAC_AUX_RESET &&
                     !ev_en_q && !ev_lock_q);
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux not cleared");

  property p_rur_block;
    @(posedge i_clk) disable iff (!i_resetn)
      (aux_s_q[`CIDAC_BIT_RUR] && i_axi_reads_pending) |=> !o_crit_read_allow;
  endproperty
  a_rur_block: assert property (p_rur_block) else $error("read passed reads");

  property p_di_limit;
    @(posedge i_clk) disable iff (!i_resetn)
      (aux_s_q[`CIDAC_BIT_DI_HI:`CIDAC_BIT_DI_LO] == `CIDAC_DI_NO_ARITH) |=> !o_arith_dual_en;
  endproperty
  a_di_limit: assert property (p_di_limit) else $error("arith dual still on");

  property p_di_full;
    @(posedge i_clk) disable iff (!i_resetn)
      (!aux_s_q[`CIDAC_BIT_FOLD] && aux_s_q[`CIDAC_BIT_DI_HI:`CIDAC_BIT_DI_LO] == `CIDAC_DI_FULL)
      |=> (o_dual_issue_en && o_arith_dual_en);
  endproperty
  a_di_full: assert property (p_di_full) else $error("dual issue off");

  property p_loop_off;
    @(posedge i_clk) disable iff (!i_resetn)
      aux_s_q[`CIDAC_BIT_LOOP] |=> (!o_loops_en && !o_loop_pred_en);
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loops still on");

  property p_event_idle;
    @(posedge i_clk) disable iff (!i_resetn)
      !ev_en_q |=> !o_event_out;
  endproperty
  a_event_idle: assert property (p_event_idle) else $error("event port active");

  property p_ns_lock_rd;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && !i_write && i_priv && !i_secure && i_addr == `CIDAC_ADDR_AUX_CTRL)
      |=> !o_rdata[`CIDAC_BIT_EV_LOCK];
  endproperty
  a_ns_lock_rd: assert property (p_ns_lock_rd) else $error("lock visible");

  property p_lock_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_req && i_write && !i_secure && ev_lock_q)
      |=> ($stable(ev_en_q) && $stable(ev_lock_q));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("event bits changed");

endmodule
`default_nettype wire

// [cidac_regs.svh]
// register offsets, field positions and reset values of the id and aux control bank
`ifndef CIDAC_REGS_SVH
`define CIDAC_REGS_SVH

`define CIDAC_ADDR_IRQ_LINES   32'hE000E004
`define CIDAC_ADDR_AUX_CTRL    32'hE000E008
`define CIDAC_ADDR_CP_POWER    32'hE000E00C
`define CIDAC_ADDR_AUX_CTRL_NS 32'hE002E008
`define CIDAC_ADDR_REVISION    32'hE000ECFC
`define CIDAC_ADDR_CACHE_GEOM  32'hE000ED80
`define CIDAC_ADDR_CACHE_SEL   32'hE000ED84

`define CIDAC_AUX_RESET        32'h00000000
`define CIDAC_CSEL_RESET       1'h0
`define CIDAC_AUX_RW_MASK      32'h08038CFC
`define CIDAC_BIT_RUW          27
`define CIDAC_BIT_DI_HI        17
`define CIDAC_BIT_DI_LO        16
`define CIDAC_BIT_RUR          15
`define CIDAC_BIT_EV_EN        14
`define CIDAC_BIT_EV_LOCK      13
`define CIDAC_BIT_TR_FLUSH     12
`define CIDAC_BIT_LOOP_BR      5
`define CIDAC_BIT_LOOP         4
`define CIDAC_BIT_FOLD         2

`define CIDAC_GEOM_ATTR        4'hF
`define CIDAC_WAYS_INSTR       10'h001
`define CIDAC_WAYS_DATA        10'h003
`define CIDAC_LINE_CODE        3'h1
`define CIDAC_DI_FULL          2'h0
`define CIDAC_DI_NO_ARITH      2'h1

`endif

// [cidac_pkg.sv]
// types shared by the id and aux control bank
package cidac_pkg;
  typedef logic [31:0] cidac_word_t;
endpackage

// [cidac_top_tb.sv]
// self-checking bench for the id and aux control register bank
`timescale 1ns/100ps
`default_nettype none
`include "cidac_regs.svh"
module cidac_top_tb;
  localparam logic [14:0] IS = 15'h007F;
  localparam logic [14:0] DS = 15'h003F;
  localparam logic [27:0] RU = 28'h0000123;
  localparam logic [3:0]  IL = 4'h5;
  localparam logic [31:0] AUX = `CIDAC_ADDR_AUX_CTRL;
  localparam logic [31:0] SEL = `CIDAC_ADDR_CACHE_SEL;
  localparam logic [31:0] GEO = `CIDAC_ADDR_CACHE_GEOM;
  localparam logic [31:0] REV = `CIDAC_ADDR_REVISION;
  logic        i_clk, i_resetn, i_cold_resetn, i_req, i_write, i_priv, i_secure, i_debug;
  logic        i_dbg_uid_en_s, i_dbg_uid_en_ns, i_axi_writes_pending, i_axi_reads_pending;
  logic        i_crit_read_req, i_event_in, i_trace_flush_valid, i_trace_flush_done;
  logic [3:0]  i_revision_number;
  logic [31:0] i_addr, i_wdata, rd, rd_b;
  logic        o_ack, o_fault, o_crit_read_allow, o_dual_issue_en, o_arith_dual_en;
  logic        o_loops_en, o_loop_pred_en, o_event_out, o_trace_flush_ready, flt;
  cidac_pkg::cidac_word_t o_rdata, o_rdata_b;
  int          failures = 0, checks = 0, cycles = 0;

  cidac_top #(.INSTR_SETS_CODE(IS), .DATA_SETS_CODE(DS), .REVISION_UPPER(RU),
    .IRQ_LINES_CODE(IL)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cold_resetn(i_cold_resetn), .i_req(i_req),
    .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .i_priv(i_priv),
    .i_secure(i_secure), .i_debug(i_debug), .i_dbg_uid_en_s(i_dbg_uid_en_s),
    .i_dbg_uid_en_ns(i_dbg_uid_en_ns), .i_revision_number(i_revision_number),
    .i_axi_writes_pending(i_axi_writes_pending), .i_axi_reads_pending(i_axi_reads_pending),
    .i_crit_read_req(i_crit_read_req), .i_event_in(i_event_in),
    .i_trace_flush_valid(i_trace_flush_valid), .i_trace_flush_done(i_trace_flush_done),
    .o_ack(o_ack), .o_fault(o_fault), .o_rdata(o_rdata),
    .o_crit_read_allow(o_crit_read_allow), .o_dual_issue_en(o_dual_issue_en),
    .o_arith_dual_en(o_arith_dual_en), .o_loops_en(o_loops_en),
    .o_loop_pred_en(o_loop_pred_en), .o_event_out(o_event_out),
    .o_trace_flush_ready(o_trace_flush_ready));

  // second copy without instruction cache or security extension, same stimulus
  cidac_top #(.INSTR_CACHE_PRESENT(1'b0), .SECURITY_EXT(1'b0), .DATA_SETS_CODE(DS),
    .REVISION_UPPER(RU)) u_bare (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_cold_resetn(i_cold_resetn), .i_req(i_req),
    .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .i_priv(i_priv),
    .i_secure(i_secure), .i_debug(i_debug), .i_dbg_uid_en_s(i_dbg_uid_en_s),
    .i_dbg_uid_en_ns(i_dbg_uid_en_ns), .i_revision_number(i_revision_number),
    .i_axi_writes_pending(i_axi_writes_pending), .i_axi_reads_pending(i_axi_reads_pending),
    .i_crit_read_req(i_crit_read_req), .i_event_in(i_event_in),
    .i_trace_flush_valid(i_trace_flush_valid), .i_trace_flush_done(i_trace_flush_done),
    .o_ack(), .o_fault(), .o_rdata(o_rdata_b), .o_crit_read_allow(), .o_dual_issue_en(),
    .o_arith_dual_en(), .o_loops_en(), .o_loop_pred_en(), .o_event_out(),
    .o_trace_flush_ready());

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask

  // one access: request held for the taking edge, answer sampled in the ack cycle
  task automatic acc(input logic w, input logic [31:0] a, d, input logic p, s, g);
    @(posedge i_clk);
    #1;
    {i_req, i_write, i_addr, i_wdata, i_priv, i_secure, i_debug} = {1'b1, w, a, d, p, s, g};
    @(posedge i_clk);
    #1;
    i_req = 1'b0;
    chk_b(o_ack, 1'b1);
    rd = o_rdata;
    rd_b = o_rdata_b;
    flt = o_fault;
  endtask

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic rst(input logic cold);
    i_resetn = 1'b0;
    i_cold_resetn = ~cold;
    repeat (10) @(posedge i_clk);
    #1;
    {i_resetn, i_cold_resetn} = 2'b11;
  endtask

  task automatic t_cache();
    acc(1, SEL, 32'h0000000F, 1, 1, 0);
    chk_w(rd, 32'h0);
    chk_b(flt, 1'b0);
    acc(0, SEL, 0, 1, 1, 0);
    chk_w(rd, 32'h1);
    acc(0, GEO, 0, 1, 1, 0);
    chk_w(rd, {`CIDAC_GEOM_ATTR, IS, `CIDAC_WAYS_INSTR, `CIDAC_LINE_CODE});
    chk_w(rd_b, 32'h0);
    acc(1, SEL, 0, 1, 1, 0);
    acc(0, GEO, 0, 1, 1, 0);
    chk_w(rd, {`CIDAC_GEOM_ATTR, DS, `CIDAC_WAYS_DATA, `CIDAC_LINE_CODE});
    chk_w(rd_b, {`CIDAC_GEOM_ATTR, DS, `CIDAC_WAYS_DATA, `CIDAC_LINE_CODE});
    acc(1, SEL, 1, 1, 0, 0);
    acc(0, SEL, 0, 1, 1, 0);
    chk_w(rd, 32'h0);
    acc(0, GEO, 0, 1, 0, 0);
    chk_w(rd, {`CIDAC_GEOM_ATTR, IS, `CIDAC_WAYS_INSTR, `CIDAC_LINE_CODE});
    acc(0, 32'hE000EF00, 0, 1, 1, 0);
    chk_w(rd, 32'h0);
  endtask

  task automatic t_fault();
    logic [31:0] a [4];
    a = '{SEL, GEO, REV, AUX};
    foreach (a[i]) begin
      acc(1, a[i], 32'h4, 0, 1, 0);
      chk_b(flt, 1'b1);
    end
    acc(0, `CIDAC_ADDR_IRQ_LINES, 0, 0, 1, 0);
    chk_w(rd, {28'h0000000, IL});
    chk_b(flt, 1'b0);
    tick();
    chk_b(o_dual_issue_en, 1'b1);
  endtask

  task automatic t_rev();
    i_revision_number = 4'hA;
    acc(1, REV, 32'hFFFFFFFF, 1, 1, 0);
    acc(0, REV, 0, 1, 1, 0);
    chk_w(rd, {RU, 4'hA});
    acc(0, REV, 0, 1, 0, 0);
    chk_w(rd, 32'h0);
    chk_w(rd_b, {RU, 4'hA});
    acc(0, REV, 0, 0, 1, 1);
    chk_b(flt, 1'b1);
    i_dbg_uid_en_ns = 1'b1;
    acc(0, REV, 0, 0, 1, 1);
    chk_w({rd[31:1], flt}, {RU, 3'h5, 1'b0});
    {i_dbg_uid_en_s, i_dbg_uid_en_ns} = 2'b10;
    acc(0, REV, 0, 0, 0, 1);
    chk_w(rd, {RU, 4'hA});
    chk_b(flt, 1'b0);
  endtask

  task automatic t_aux();
    logic [31:0] wv [5];
    logic [3:0]  ex [5];
    wv = '{32'h4, 32'h10000, 32'h10, 32'h20, 32'h0};
    ex = '{4'h3, 4'hB, 4'hC, 4'hE, 4'hF};
    foreach (wv[i]) begin
      acc(1, AUX, wv[i], 1, 1, 0);
      tick();
      chk_w({o_dual_issue_en, o_arith_dual_en, o_loops_en, o_loop_pred_en}, ex[i]);
    end
    acc(1, `CIDAC_ADDR_AUX_CTRL_NS, 32'h4, 1, 1, 0);
    acc(0, AUX, 0, 1, 0, 0);
    chk_w(rd, 32'h4);
    chk_b(o_dual_issue_en, 1'b1);
    i_crit_read_req = 1'b1;
    {i_axi_writes_pending, i_axi_reads_pending} = 2'b11;
    acc(1, AUX, 32'h08000000, 1, 1, 0);
    tick();
    chk_b(o_crit_read_allow, 1'b0);
    i_axi_writes_pending = 1'b0;
    tick();
    chk_b(o_crit_read_allow, 1'b1);
    acc(1, AUX, 32'h00008000, 1, 1, 0);
    tick();
    chk_b(o_crit_read_allow, 1'b0);
  endtask

  task automatic t_event();
    i_event_in = 1'b1;
    acc(1, AUX, 32'h00006000, 1, 1, 0);
    tick();
    chk_b(o_event_out, 1'b1);
    i_event_in = 1'b0;
    tick();
    chk_b(o_event_out, 1'b0);
    i_event_in = 1'b1;
    acc(0, AUX, 0, 1, 0, 0);
    chk_b(rd[13], 1'b0);
    acc(1, AUX, 0, 1, 0, 0);
    tick();
    chk_b(o_event_out, 1'b1);
    acc(1, AUX, 32'h00005004, 1, 1, 0);
    tick();
    chk_b(o_trace_flush_ready, 1'b1);
    rst(1'b0);
    acc(0, AUX, 0, 1, 1, 0);
    chk_w(rd, 32'h00001000);
    rst(1'b1);
    acc(0, AUX, 0, 1, 1, 0);
    chk_w(rd, `CIDAC_AUX_RESET);
    acc(1, AUX, 32'h00004000, 1, 1, 0);
    acc(0, AUX, 0, 1, 0, 0);
    chk_b(rd[14], 1'b1);
    acc(1, AUX, 0, 1, 0, 0);
    tick();
    chk_b(o_event_out, 1'b0);
    {i_trace_flush_valid, i_trace_flush_done} = 2'b10;
    tick();
    chk_b(o_trace_flush_ready, 1'b0);
    i_trace_flush_done = 1'b1;
    tick();
    chk_b(o_trace_flush_ready, 1'b1);
  endtask

  initial begin
    {i_req, i_write, i_addr, i_wdata, i_priv, i_secure, i_debug} = '0;
    {i_dbg_uid_en_s, i_dbg_uid_en_ns, i_axi_writes_pending, i_axi_reads_pending} = '0;
    {i_crit_read_req, i_event_in, i_trace_flush_valid, i_trace_flush_done} = '0;
    i_revision_number = 4'h0;
    // let the reset processes start waiting before the first falling reset edge
    #1;
    rst(1'b1);
    acc(0, AUX, 0, 1, 1, 0);
    chk_w(rd, `CIDAC_AUX_RESET);
    t_cache();
    t_fault();
    t_rev();
    t_aux();
    t_event();
    summarize();
  end
endmodule
`default_nettype wire
